// ### cch_serial_ctl.sv
// per-channel serial control inputs and serial monitor outputs
// assumes a 256 kHz bit clock pin and a frame sync pin from the system timing
//
// Function
// RULE1: bypass bit bypasses channel, resets coefficients
// RULE2: suppressor-off bit disables that channel's suppressor
// RULE3: hold bit freezes that channel's coefficients
// RULE4: law-conversion-off bit stops companding conversion
// RULE5: clear-channel bit equals bypass plus conversion-off
// RULE6: flex bit function chosen by select setting
// RULE7: controls active high, maskable, idle low
// RULE8: bypass monitor: 0 cancelling, 1 bypassed
// RULE9: suppressor monitor: 0 active, 1 off
// RULE10: hold monitor: 1 frozen, 0 otherwise
// RULE11: reset monitor: 1 while coefficients reset
// RULE12: two detector streams, selects upper/lower nibble
// RULE13: detector choices: idle, tones, talk, silence
// RULE14: law monitor: 1 conversion disabled
// RULE15: clear monitor: 1 transparent, consistent
// RULE16: one bit per channel, channel 0 first
// RULE17: monitors show effective state after masking
`timescale 1ns/100ps
`default_nettype none

module cch_serial_ctl
    import cch_pkg::*;
(
    // clock and reset
    input  wire logic         MCLK,
    input  wire logic         RST,
    // frame timing pins
    input  wire logic         BIT_CLK,
    input  wire logic         FRAME_SYNC,
    // serial control pins
    input  wire logic         BYPASS_CTL_IN,
    input  wire logic         SUPPRESSOR_OFF_IN,
    input  wire logic         COEFF_HOLD_IN,
    input  wire logic         LAW_CONV_OFF_IN,
    input  wire logic         CLEAR_CHANNEL_IN,
    input  wire logic         FLEX_CTL_IN,
    // configuration
    input  wire cch_bits_type CTL_MASK,
    input  wire logic [2:0]   FLEX_CTL_SELECT,
    input  wire logic [7:0]   DETECTOR_SELECT,
    // detector flags from the canceller core
    input  wire cch_det_type  DET_FLAGS,
    // effective state to the canceller core
    output var  cch_ctl_type  CTL_STATE,
    // serial monitor pins
    output var  cch_mon_type  MON_OUT
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic det_pick(input logic [3:0] sel, input cch_det_type d,
                                      input logic [`CCH_CH_W-1:0] ch);
        logic r;
        r = 1'b0;
        case (sel)
            `CCH_DET_IDLE:      r = d.idle[ch];
            `CCH_DET_T2010:     r = d.tone_2010[ch];
            `CCH_DET_T2100:     r = d.tone_2100[ch];
            `CCH_DET_T2100_PR:  r = d.tone_2100[ch] & d.phase_rev[ch];
            `CCH_DET_T2100_NPR: r = d.tone_2100[ch] & ~d.phase_rev[ch];
            `CCH_DET_DTALK:     r = d.double_talk[ch];
            `CCH_DET_NOSPEECH:  r = d.no_speech[ch];
            default:            r = 1'b0;
        endcase
        return r;
    endfunction : det_pick

    function automatic logic flex_hit(input logic [2:0] sel, input logic [2:0] code,
                                      input logic bit_in);
        return bit_in & (sel == code);
    endfunction : flex_hit

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int NPIN = 8;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] meta_ff;
    logic [NPIN-1:0] sync_ff;
    logic            bclk_d_ff;

    assign pin_raw = {BIT_CLK, FRAME_SYNC, BYPASS_CTL_IN, SUPPRESSOR_OFF_IN,
                      COEFF_HOLD_IN, LAW_CONV_OFF_IN, CLEAR_CHANNEL_IN, FLEX_CTL_IN};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            // no reset: a pin held high over reset is no edge
            always_ff @(posedge MCLK)
            begin
                meta_ff[gi] <= pin_raw[gi];
                sync_ff[gi] <= meta_ff[gi];
            end
        end
    endgenerate

    logic         bclk_s;
    logic         fsync_s;
    logic         bit_edge;
    cch_bits_type raw_bits;

    assign bclk_s   = sync_ff[7];
    assign fsync_s  = sync_ff[6];
    assign bit_edge = bclk_s & ~bclk_d_ff;
    assign raw_bits = cch_bits_type'(sync_ff[5:0]);

    // tracks through reset so release gives no false slot
    always_ff @(posedge MCLK)
    begin
        bclk_d_ff <= bclk_s;                                        // RULE16
    end

    // ------------------------------------------------------------------
    // channel counter
    // ------------------------------------------------------------------
    logic [`CCH_CH_W-1:0] ch_ff;
    logic [`CCH_CH_W-1:0] nxt_ch;

    always_comb
    begin
        if (fsync_s)
            nxt_ch = '0;                                            // RULE16
        else
            nxt_ch = ch_ff + `CCH_CH_W'(1);                         // RULE16
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            ch_ff <= `CCH_CH_RST;
        else if (bit_edge)
            ch_ff <= nxt_ch;
    end

    // ------------------------------------------------------------------
    // effective control bits for the channel now on the wire
    // ------------------------------------------------------------------
    cch_bits_type in_bits;
    logic         eff_bypass;
    logic         eff_supp;
    logic         eff_hold;
    logic         eff_conv;
    logic         eff_clear;

    always_comb
    begin
        in_bits   = raw_bits & ~CTL_MASK;                           // RULE7
        eff_clear = in_bits.clear
                  | flex_hit(FLEX_CTL_SELECT, `CCH_FLEX_CLEAR, in_bits.flex);       // RULE6
        eff_bypass = in_bits.bypass | eff_clear                     // RULE5
                   | flex_hit(FLEX_CTL_SELECT, `CCH_FLEX_BYPASS, in_bits.flex);     // RULE1
        eff_supp  = in_bits.supp_off | eff_bypass                   // RULE2
                  | flex_hit(FLEX_CTL_SELECT, `CCH_FLEX_SUPP, in_bits.flex);
        eff_hold  = in_bits.hold                                    // RULE3
                  | flex_hit(FLEX_CTL_SELECT, `CCH_FLEX_HOLD, in_bits.flex);
        eff_conv  = in_bits.conv_off | eff_clear                    // RULE4
                  | flex_hit(FLEX_CTL_SELECT, `CCH_FLEX_CONV, in_bits.flex);
    end

    // ------------------------------------------------------------------
    // per-channel state store
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (RST)
            CTL_STATE <= '0;
        else if (bit_edge)
        begin
            CTL_STATE.bypass[nxt_ch]      <= eff_bypass;            // RULE1
            CTL_STATE.coeff_reset[nxt_ch] <= eff_bypass;            // RULE1
            CTL_STATE.supp_off[nxt_ch]    <= eff_supp;              // RULE2
            CTL_STATE.hold[nxt_ch]        <= eff_hold;              // RULE3
            CTL_STATE.conv_off[nxt_ch]    <= eff_conv;              // RULE4
            CTL_STATE.clear[nxt_ch]       <= eff_clear;             // RULE5
        end
    end

    // ------------------------------------------------------------------
    // serial monitor outputs
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (RST)
            MON_OUT <= '0;
        else if (bit_edge)
        begin
            MON_OUT.bypass_state_out        <= eff_bypass;          // RULE8 RULE17
            MON_OUT.suppressor_state_out    <= eff_supp;            // RULE9
            MON_OUT.coeff_hold_state_out    <= eff_hold;            // RULE10
            MON_OUT.coeff_reset_state_out   <= eff_bypass;          // RULE11
            MON_OUT.law_conv_state_out      <= eff_conv;            // RULE14
            MON_OUT.clear_channel_state_out <= eff_clear;           // RULE15
            MON_OUT.detector_stream_a <= det_pick(DETECTOR_SELECT[`CCH_DSEL_A_HI:`CCH_DSEL_A_LO],
                                                  DET_FLAGS, nxt_ch);      // RULE12 RULE13
            MON_OUT.detector_stream_b <= det_pick(DETECTOR_SELECT[`CCH_DSEL_B_HI:`CCH_DSEL_B_LO],
                                                  DET_FLAGS, nxt_ch);      // RULE12 RULE13
        end
    end

endmodule : cch_serial_ctl

`default_nettype wire

// ### cch_regs.svh
// constants of the per-channel serial control and monitor block
// assumes inclusion from the package and the top module only
`ifndef CCH_REGS_SVH
`define CCH_REGS_SVH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define CCH_NUM_CH        32
`define CCH_CH_W          5
`define CCH_LAST_CH       5'h1f
`define CCH_CH_RST        5'h1f

// ----------------------------------------------------------------------
// flex control function codes
// ----------------------------------------------------------------------
`define CCH_FLEX_NONE     3'h0
`define CCH_FLEX_BYPASS   3'h1
`define CCH_FLEX_SUPP     3'h2
`define CCH_FLEX_HOLD     3'h3
`define CCH_FLEX_CONV     3'h4
`define CCH_FLEX_CLEAR    3'h5

// ----------------------------------------------------------------------
// detector select field positions and codes
// ----------------------------------------------------------------------
`define CCH_DSEL_A_HI     7
`define CCH_DSEL_A_LO     4
`define CCH_DSEL_B_HI     3
`define CCH_DSEL_B_LO     0
`define CCH_DET_OFF       4'h0
`define CCH_DET_IDLE      4'h1
`define CCH_DET_T2010     4'h2
`define CCH_DET_T2100     4'h3
`define CCH_DET_T2100_PR  4'h4
`define CCH_DET_T2100_NPR 4'h5
`define CCH_DET_DTALK     4'h6
`define CCH_DET_NOSPEECH  4'h7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CCH_VEC_RST       32'h0000_0000
`define CCH_BITS_RST      6'h00

`endif

// ### cch_pkg.sv
// types shared by the per-channel serial control and monitor block
// assumes cch_regs.svh is reachable by bare name
`include "cch_regs.svh"

package cch_pkg;

    // one bit of each serial control stream
    typedef struct packed {
        logic bypass;
        logic supp_off;
        logic hold;
        logic conv_off;
        logic clear;
        logic flex;
    } cch_bits_type;

    // effective per-channel state, one bit per channel
    typedef struct packed {
        logic [`CCH_NUM_CH-1:0] bypass;
        logic [`CCH_NUM_CH-1:0] supp_off;
        logic [`CCH_NUM_CH-1:0] hold;
        logic [`CCH_NUM_CH-1:0] coeff_reset;
        logic [`CCH_NUM_CH-1:0] conv_off;
        logic [`CCH_NUM_CH-1:0] clear;
    } cch_ctl_type;

    // per-channel detector flags from the canceller core
    typedef struct packed {
        logic [`CCH_NUM_CH-1:0] idle;
        logic [`CCH_NUM_CH-1:0] tone_2010;
        logic [`CCH_NUM_CH-1:0] tone_2100;
        logic [`CCH_NUM_CH-1:0] phase_rev;
        logic [`CCH_NUM_CH-1:0] double_talk;
        logic [`CCH_NUM_CH-1:0] no_speech;
    } cch_det_type;

    // serial monitor stream bits
    typedef struct packed {
        logic bypass_state_out;
        logic suppressor_state_out;
        logic coeff_hold_state_out;
        logic coeff_reset_state_out;
        logic law_conv_state_out;
        logic clear_channel_state_out;
        logic detector_stream_a;
        logic detector_stream_b;
    } cch_mon_type;

endpackage : cch_pkg

// ### cch_far_end.sv
// far-end framer model driving the serial control pins
// assumes one 32-bit channel vector per control pin from the bench
`timescale 1ns/100ps
`default_nettype none
module cch_far_end
    import cch_pkg::*;
#(
    parameter int HALF = 49
)
(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // channel vectors and monitor pins
    input  wire logic [191:0] vec,
    input  wire cch_mon_type  mon,
    // serial pins
    output var  logic         bit_clk,
    output var  logic         frame_sync,
    output var  cch_bits_type pins,
    // captured monitor frame
    output var  logic [255:0] capt,
    output var  int           frames
);
    int         div;
    logic [4:0] ch;
    // ----
    // slot timing, data changes at falling bit clock
    // ----
    initial {bit_clk, frame_sync, pins, frames} = '0;
    always @(posedge mclk)
    begin
        #1;
        div = (rst || div == 2 * HALF - 1) ? 0 : div + 1;
        if (rst)
            ch = 5'h1f;
        if (div == 0 && !rst)
            bit_clk = 1'b1;
        if (div == HALF)
        begin
            bit_clk = 1'b0;
            for (int k = 0; k < 8; k++)
                capt[32 * k + int'(ch)] = mon[k];
            frames = frames + int'(ch == 5'h1f);
            ch = ch + 5'h01;
            frame_sync = (ch == 5'h00);
            for (int k = 0; k < 6; k++)
                pins[k] = vec[32 * k + int'(ch)];
        end
    end
endmodule : cch_far_end
`default_nettype wire

// ### cch_serial_ctl_assertions.sv
// checker on the serial control block ports
// assumes serial pins change only near falling bit clock
`timescale 1ns/100ps
`default_nettype none
module cch_serial_ctl_chk
    import cch_pkg::*;
(
    // clock, reset, timing
    input wire logic         MCLK,
    input wire logic         RST,
    input wire logic         BIT_CLK,
    input wire logic         FRAME_SYNC,
    // serial control pins
    input wire logic         BYPASS_CTL_IN,
    input wire logic         SUPPRESSOR_OFF_IN,
    input wire logic         COEFF_HOLD_IN,
    input wire logic         LAW_CONV_OFF_IN,
    input wire logic         CLEAR_CHANNEL_IN,
    input wire logic         FLEX_CTL_IN,
    // configuration and outputs
    input wire cch_bits_type CTL_MASK,
    input wire logic [2:0]   FLEX_CTL_SELECT,
    input wire cch_ctl_type  CTL_STATE,
    input wire cch_mon_type  MON_OUT
);
    logic       bclk_d_ff, armed_ff;
    logic [4:0] ch_ff;
    logic [5:0] pin_ff;
    logic       fl, eb, ec, ecl;
    wire  [2:0] fs = FLEX_CTL_SELECT;
    // ----
    // slot tracking and expected state
    // ----
    always_ff @(posedge MCLK) bclk_d_ff <= BIT_CLK;
    always_ff @(posedge MCLK) pin_ff <= {BYPASS_CTL_IN, SUPPRESSOR_OFF_IN, COEFF_HOLD_IN, LAW_CONV_OFF_IN,
        CLEAR_CHANNEL_IN, FLEX_CTL_IN} & ~CTL_MASK;
    always_ff @(posedge MCLK) armed_ff <= !RST && (armed_ff || (BIT_CLK && !bclk_d_ff));
    always_ff @(posedge MCLK)
        ch_ff <= RST ? 5'h1f : !(BIT_CLK && !bclk_d_ff) ? ch_ff : FRAME_SYNC ? 5'h00 : ch_ff + 5'h01;
    assign fl  = bclk_d_ff & ~BIT_CLK & armed_ff;
    assign eb  = pin_ff[5] | pin_ff[1] | (pin_ff[0] & (fs == 3'h1 || fs == 3'h5));
    assign ec  = pin_ff[2] | pin_ff[1] | (pin_ff[0] & (fs == 3'h4 || fs == 3'h5));
    assign ecl = pin_ff[1] | (pin_ff[0] & fs == 3'h5);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    property p_bypass; fl |-> MON_OUT.bypass_state_out == eb; endproperty
    a_bypass: assert property (p_bypass) else $error("bypass monitor wrong");
    property p_supp; fl |-> MON_OUT.suppressor_state_out == (pin_ff[4] | eb | (pin_ff[0] & fs == 3'h2)); endproperty
    a_supp: assert property (p_supp) else $error("suppressor monitor wrong");
    property p_hold; fl |-> MON_OUT.coeff_hold_state_out == (pin_ff[3] | (pin_ff[0] & fs == 3'h3)); endproperty
    a_hold: assert property (p_hold) else $error("hold monitor wrong");
    property p_reset; fl |-> MON_OUT.coeff_reset_state_out == eb; endproperty
    a_reset: assert property (p_reset) else $error("reset monitor wrong");
    property p_law; fl |-> MON_OUT.law_conv_state_out == ec; endproperty
    a_law: assert property (p_law) else $error("law monitor wrong");
    property p_clear; fl |-> MON_OUT.clear_channel_state_out == ecl && (!MON_OUT.clear_channel_state_out
        || MON_OUT.bypass_state_out && MON_OUT.law_conv_state_out); endproperty
    a_clear: assert property (p_clear) else $error("clear monitor wrong");
    property p_stand; (bclk_d_ff && !BIT_CLK) |=> $stable(MON_OUT) [*8]; endproperty
    a_stand: assert property (p_stand) else $error("monitor changed mid slot");
    property p_state; fl |-> CTL_STATE.bypass[ch_ff] == eb && CTL_STATE.conv_off[ch_ff] == ec; endproperty
    a_state: assert property (p_state) else $error("state vector wrong");
endmodule : cch_serial_ctl_chk
bind cch_serial_ctl cch_serial_ctl_chk u_chk (.MCLK(MCLK), .RST(RST), .BIT_CLK(BIT_CLK), .FRAME_SYNC(FRAME_SYNC),
    .BYPASS_CTL_IN(BYPASS_CTL_IN), .SUPPRESSOR_OFF_IN(SUPPRESSOR_OFF_IN), .COEFF_HOLD_IN(COEFF_HOLD_IN),
    .LAW_CONV_OFF_IN(LAW_CONV_OFF_IN), .CLEAR_CHANNEL_IN(CLEAR_CHANNEL_IN), .FLEX_CTL_IN(FLEX_CTL_IN),
    .CTL_MASK(CTL_MASK), .FLEX_CTL_SELECT(FLEX_CTL_SELECT), .CTL_STATE(CTL_STATE), .MON_OUT(MON_OUT));
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the serial control block
// assumes the far-end model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`define TB_CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module tb_top
    import cch_pkg::*;
;
    logic         mclk = 1'b0;
    logic         rst  = 1'b1;
    logic [191:0] vec  = '0;
    cch_bits_type mask = '0;
    logic [2:0]   fsel = 3'h0;
    logic [7:0]   dsel = 8'h00;
    cch_det_type  det  = '0;
    logic         bit_clk, frame_sync;
    cch_bits_type pins;
    cch_ctl_type  ctl;
    cch_mon_type  mon;
    logic [255:0] capt;
    int           frames, errors = 0, checks_done = 0;
    always #20 mclk = ~mclk;
    // ----
    // far end and block, shorter slot keeps the run brief
    // ----
    cch_far_end #(.HALF(16)) u_far (.mclk(mclk), .rst(rst), .vec(vec), .mon(mon), .bit_clk(bit_clk),
        .frame_sync(frame_sync), .pins(pins), .capt(capt), .frames(frames));
    cch_serial_ctl u_dut (.MCLK(mclk), .RST(rst), .BIT_CLK(bit_clk), .FRAME_SYNC(frame_sync),
        .BYPASS_CTL_IN(pins.bypass), .SUPPRESSOR_OFF_IN(pins.supp_off), .COEFF_HOLD_IN(pins.hold),
        .LAW_CONV_OFF_IN(pins.conv_off), .CLEAR_CHANNEL_IN(pins.clear), .FLEX_CTL_IN(pins.flex),
        .CTL_MASK(mask), .FLEX_CTL_SELECT(fsel), .DETECTOR_SELECT(dsel), .DET_FLAGS(det),
        .CTL_STATE(ctl), .MON_OUT(mon));
    function automatic logic [31:0] dvec(input logic [3:0] c);
        logic [31:0] d[8] = '{32'h0, det.idle, det.tone_2010, det.tone_2100, det.tone_2100 & det.phase_rev,
            det.tone_2100 & ~det.phase_rev, det.double_talk, det.no_speech};
        return c[3] ? 32'h0 : d[c[2:0]];
    endfunction : dvec
    function automatic logic [255:0] expect_all();
        logic [31:0] v[6];
        logic [31:0] eb;
        for (int k = 0; k < 6; k++)
            v[k] = vec[32 * k +: 32] & ~{32{mask[k]}};
        eb = v[5] | v[1] | (v[0] & {32{fsel == 3'h1 || fsel == 3'h5}});
        return {eb, v[4] | eb | (v[0] & {32{fsel == 3'h2}}), v[3] | (v[0] & {32{fsel == 3'h3}}), eb,
            v[2] | v[1] | (v[0] & {32{fsel == 3'h4 || fsel == 3'h5}}), v[1] | (v[0] & {32{fsel == 3'h5}}),
            dvec(dsel[7:4]), dvec(dsel[3:0])};
    endfunction : expect_all
    task automatic check_frame();
        int f = frames;
        logic [255:0] e;
        for (int i = 0; i < 5000 && frames < f + 2; i++)
            @(posedge mclk);
        if (frames < f + 2)
        begin
            errors++;
            $display("[FAIL] %0t frame count stalled", $time);
        end
        #1;
        e = expect_all();
        `TB_CHK(capt, e)
        `TB_CHK(ctl, e[255:64])
    endtask : check_frame
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // ----
    // scenarios
    // ----
    task automatic t_basic();
        vec = {32'h8000_0003, 32'h0000_0020, 32'h0000_0081, 32'h0000_0200, 32'h0000_1000, 32'h0};
        check_frame();
        $display("done t_basic");
    endtask : t_basic
    task automatic t_mask();
        vec = '1;
        fsel = 3'h5;
        for (int k = 0; k < 7; k++)
        begin
            mask = 6'h3f ^ (6'h20 >> k);
            check_frame();
        end
        mask = '0;
        $display("done t_mask");
    endtask : t_mask
    task automatic t_flex();
        vec = {160'h0, 32'hf0f0_00f1};
        for (int k = 0; k < 8; k++)
        begin
            fsel = 3'(k);
            check_frame();
        end
        $display("done t_flex");
    endtask : t_flex
    task automatic t_det();
        vec = '0;
        det = {32'h0000_ffff, 32'h00ff_00ff, 32'h0f0f_0f0f, 32'h3333_3333, 32'h5555_5555, 32'haaaa_aaaa};
        for (int k = 0; k < 9; k++)
        begin
            dsel = {4'(k), 4'(8 - k)};
            check_frame();
        end
        $display("done t_det");
    endtask : t_det
    task automatic t_reset();
        vec = '1;
        repeat (50) @(posedge mclk);
        #1 rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        `TB_CHK(mon, 8'h00)
        `TB_CHK(ctl, 192'h0)
        rst = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        `TB_CHK(mon, 8'h00)
        check_frame();
        $display("done t_reset");
    endtask : t_reset
    initial
    begin
        repeat (20) @(posedge mclk);
        #1 rst = 1'b0;
        t_basic();
        t_mask();
        t_flex();
        t_det();
        t_reset();
        tally_and_finish();
    end
    initial
    begin
        repeat (90000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
